// >>> logic/rcsr_core.sv
//
// Overview of operation
// - opcode with top five bits 11011 is a relative call; low eleven bits are offset
// - the call offset is two's complement, from -1024 up to 1023
// - the call pushes pc plus 2 onto the return stack before touching pc
// - the call loads pc with pc plus 2 plus twice the signed offset
// - the target is built from the advanced pc, not the call's own address
// - the call takes two cycles; the second is a refill with no operation
// - the call leaves every status flag as it was
// - opcode 0x00ff is the software reset, with no operands
// - software reset raises the same reset as the master clear pin
// - software reset takes one cycle: decode in q1, reset request in q2
//
`timescale 1ns/1ps
module rcsr_core #(
	parameter int PC_WIDTH   = rcsr_pkg::PC_WIDTH_DEF,
	parameter int CLKS_PER_Q = rcsr_pkg::Q_CLKS_DEF
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic [15:0]         opcode,
	input  wire logic                opcode_valid,
	input  wire logic [PC_WIDTH-1:0] pc_now,
	output logic                     push_strobe,
	output logic [PC_WIDTH-1:0]      push_addr,
	output logic                     pc_load,
	output logic [PC_WIDTH-1:0]      pc_target,
	output logic                     master_clear_pin_reset_req,
	output logic                     refill_busy,
	output logic                     flags_freeze
);
	localparam int OW          = rcsr_pkg::OFF_WIDTH;
	localparam int LOAD_TO_END = 4 * CLKS_PER_Q;
	localparam int REFILL_LEN  = 4 * CLKS_PER_Q;

	if (PC_WIDTH < OW + 1) begin : g_bad_width
		$error("rcsr_core: PC_WIDTH must be at least 12");
	end
	if (CLKS_PER_Q < 1) begin : g_bad_clks
		$error("rcsr_core: CLKS_PER_Q must be at least 1");
	end

	// doubled, sign-extended offset
	function automatic logic [PC_WIDTH-1:0] span_of(input logic [OW-1:0] n);
		return {{(PC_WIDTH-OW-1){n[OW-1]}}, n, 1'b0};
	endfunction : span_of

	// address following the current instruction
	function automatic logic [PC_WIDTH-1:0] step_of(input logic [PC_WIDTH-1:0] a);
		return a + PC_WIDTH'(rcsr_pkg::RET_STEP);
	endfunction : step_of

	rcsr_q_if q ();

	rcsr_qphase #(
		.CLKS_PER_Q (CLKS_PER_Q)
	) u_qphase (
		.clk (clk),
		.rst (rst),
		.q   (q)
	);

	rcsr_pkg::rcsr_op_type dec_op;
	logic [OW-1:0]         dec_off;

	rcsr_decode u_decode (
		.opcode (opcode),
		.op     (dec_op),
		.offset (dec_off)
	);

	rcsr_pkg::rcsr_state_type state;
	rcsr_pkg::rcsr_state_type next_state;
	rcsr_pkg::rcsr_op_type    op;
	rcsr_pkg::rcsr_op_type    next_op;
	logic [OW-1:0]            off;
	logic [OW-1:0]            next_off;
	logic [PC_WIDTH-1:0]      base;
	logic [PC_WIDTH-1:0]      next_base;
	logic                     next_push_strobe;
	logic [PC_WIDTH-1:0]      next_push_addr;
	logic                     next_pc_load;
	logic [PC_WIDTH-1:0]      next_pc_target;
	logic                     next_reset_req;
	logic                     next_refill_busy;
	logic                     next_flags_freeze;
	logic                     q1_take;

	// a new instruction is taken at the end of q1, never during refill
	assign q1_take = q.q_tick && (q.phase == rcsr_pkg::Q1)
		&& (state == rcsr_pkg::ST_EXEC) && opcode_valid;

	always_comb begin
		next_state        = state;
		next_op           = op;
		next_off          = off;
		next_base         = base;
		next_push_strobe  = 1'b0;
		next_push_addr    = push_addr;
		next_pc_load      = 1'b0;
		next_pc_target    = pc_target;
		next_reset_req    = 1'b0;
		next_refill_busy  = refill_busy;
		next_flags_freeze = flags_freeze;
		if (q.q_tick) begin
			case (q.phase)
				rcsr_pkg::Q1: begin
					if (q1_take) begin
						next_op   = dec_op;
						next_off  = dec_off;
						next_base = pc_now;
						if (dec_op == rcsr_pkg::OP_CALL) begin
							next_push_strobe  = 1'b1;
							next_push_addr    = step_of(pc_now);
							next_flags_freeze = 1'b1;
						end
						if (dec_op == rcsr_pkg::OP_RESET) begin
							next_reset_req = 1'b1;
						end
					end else if (state == rcsr_pkg::ST_EXEC) begin
						next_op = rcsr_pkg::OP_NONE;
					end
				end
				rcsr_pkg::Q2: begin
					if (op == rcsr_pkg::OP_CALL) begin
						// advanced pc plus doubled signed offset
						next_pc_target = step_of(base) + span_of(off);
					end
				end
				rcsr_pkg::Q3: begin
					if (op == rcsr_pkg::OP_CALL) begin
						next_pc_load = 1'b1;
					end
				end
				rcsr_pkg::Q4: begin
					if (state == rcsr_pkg::ST_REFILL) begin
						next_state        = rcsr_pkg::ST_EXEC;
						next_refill_busy  = 1'b0;
						next_flags_freeze = 1'b0;
					end else if (op == rcsr_pkg::OP_CALL) begin
						next_state       = rcsr_pkg::ST_REFILL;
						next_refill_busy = 1'b1;
					end
					next_op = rcsr_pkg::OP_NONE;
				end
				default: begin
					next_op = rcsr_pkg::OP_NONE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state                      <= rcsr_pkg::STATE_RST;
			op                         <= rcsr_pkg::OP_RST;
			off                        <= '0;
			base                       <= '0;
			push_strobe                <= rcsr_pkg::PULSE_RST;
			push_addr                  <= '0;
			pc_load                    <= rcsr_pkg::PULSE_RST;
			pc_target                  <= '0;
			master_clear_pin_reset_req <= rcsr_pkg::PULSE_RST;
			refill_busy                <= rcsr_pkg::PULSE_RST;
			flags_freeze               <= rcsr_pkg::PULSE_RST;
		end else begin
			state                      <= next_state;
			op                         <= next_op;
			off                        <= next_off;
			base                       <= next_base;
			push_strobe                <= next_push_strobe;
			push_addr                  <= next_push_addr;
			pc_load                    <= next_pc_load;
			pc_target                  <= next_pc_target;
			master_clear_pin_reset_req <= next_reset_req;
			refill_busy                <= next_refill_busy;
			flags_freeze               <= next_flags_freeze;
		end
	end

	// checking helpers
	logic                pushed;
	logic [PC_WIDTH-1:0] delta;
	int                  refill_len;

	assign delta = pc_target - push_addr;

	always_ff @(posedge clk) begin
		if (rst) begin
			pushed <= 1'b0;
		end else if (push_strobe) begin
			pushed <= 1'b1;
		end else if (q1_take) begin
			pushed <= 1'b0;
		end
	end

	// clocks spent in the current refill, cleared outside it
	always_ff @(posedge clk) begin
		if (rst) begin
			refill_len <= 0;
		end else if (refill_busy) begin
			refill_len <= refill_len + 1;
		end else begin
			refill_len <= 0;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence seq_call_taken;
		q1_take && (opcode[rcsr_pkg::PREFIX_MSB:rcsr_pkg::PREFIX_LSB] == rcsr_pkg::CALL_PREFIX);
	endsequence

	sequence seq_reset_taken;
		q1_take && (opcode == rcsr_pkg::RESET_OPCODE);
	endsequence

	sequence seq_call_issue;
		op == rcsr_pkg::OP_CALL && push_strobe;
	endsequence

	chk_call_decode: assert property (seq_call_taken |=> seq_call_issue)
		else $error("relative call opcode not decoded");

	chk_offset_sign: assert property (pc_load |->
		delta[PC_WIDTH-1:OW+1] == {(PC_WIDTH-OW-1){off[OW-1]}})
		else $error("call offset not sign extended");

	chk_push_addr: assert property (push_strobe |-> push_addr == step_of(base))
		else $error("pushed return address is not pc plus 2");

	chk_push_first: assert property (pc_load |-> pushed && !push_strobe)
		else $error("pc written before the return push");

	chk_target_add: assert property (pc_load |-> delta[OW:0] == {off, 1'b0})
		else $error("call target is not return address plus 2n");

	chk_base_advanced: assert property (pc_load |->
		(push_addr - base) == PC_WIDTH'(rcsr_pkg::RET_STEP))
		else $error("target not built from the advanced pc");

	chk_refill_entry: assert property (pc_load |-> ##[1:LOAD_TO_END] refill_busy)
		else $error("call did not enter its refill cycle");

	chk_refill_quiet: assert property (state == rcsr_pkg::ST_REFILL |->
		refill_busy && !push_strobe && !pc_load && !master_clear_pin_reset_req)
		else $error("activity during refill cycle");

	chk_flags_kept: assert property ((pc_load || refill_busy) |-> flags_freeze)
		else $error("status flags not held during call");

	chk_reset_decode: assert property (seq_reset_taken |=>
		master_clear_pin_reset_req && !push_strobe)
		else $error("software reset opcode not decoded");

	chk_reset_single: assert property (master_clear_pin_reset_req |->
		op == rcsr_pkg::OP_RESET && !refill_busy ##1 !master_clear_pin_reset_req)
		else $error("reset request malformed");

	chk_push_single: assert property (push_strobe |=> !push_strobe)
		else $error("stack push longer than one clock");

	chk_load_follows: assert property (push_strobe |-> ##[1:LOAD_TO_END] pc_load)
		else $error("pc write did not follow the return push");

	chk_push_only_call: assert property (push_strobe |->
		op == rcsr_pkg::OP_CALL && !master_clear_pin_reset_req)
		else $error("stack push without a relative call");

	chk_load_single: assert property (pc_load |=> !pc_load)
		else $error("pc write longer than one clock");

	chk_target_steady: assert property (pc_load |-> $stable(pc_target))
		else $error("call target moved while pc was written");

	chk_refill_bound: assert property (refill_busy |-> refill_len < REFILL_LEN)
		else $error("refill cycle too long");

	chk_refill_exit: assert property (!refill_busy |->
		refill_len == 0 || refill_len == REFILL_LEN)
		else $error("refill cycle cut short");

	chk_freeze_at_push: assert property (push_strobe |-> flags_freeze)
		else $error("status flags not frozen at the return push");

	chk_freeze_owner: assert property (flags_freeze |->
		refill_busy || op == rcsr_pkg::OP_CALL)
		else $error("status flags frozen outside a call");

	chk_reset_alone: assert property (master_clear_pin_reset_req |->
		!flags_freeze && !pc_load)
		else $error("reset request mixed with call activity");

endmodule : rcsr_core

// >>> logic/rcsr_pkg.sv
package rcsr_pkg;

	localparam int          PC_WIDTH_DEF = 21;
	localparam int          Q_CLKS_DEF   = 1;
	localparam int          OFF_WIDTH    = 11;
	localparam int          OFF_MIN      = -1024;
	localparam int          OFF_MAX      = 1023;
	localparam int          RET_STEP     = 2;
	localparam int          PREFIX_MSB   = 15;
	localparam int          PREFIX_LSB   = 11;
	localparam logic [4:0]  CALL_PREFIX  = 5'h1b;
	localparam logic [15:0] RESET_OPCODE = 16'h00ff;
	localparam logic        PULSE_RST    = 1'b0;

	typedef enum logic [1:0] {
		Q1 = 2'b00,
		Q2 = 2'b01,
		Q3 = 2'b10,
		Q4 = 2'b11
	} rcsr_phase_type;

	typedef enum logic [1:0] {
		OP_NONE  = 2'b00,
		OP_CALL  = 2'b01,
		OP_RESET = 2'b10
	} rcsr_op_type;

	typedef enum logic {
		ST_EXEC   = 1'b0,
		ST_REFILL = 1'b1
	} rcsr_state_type;

	localparam rcsr_phase_type PHASE_RST = Q1;
	localparam rcsr_state_type STATE_RST = ST_EXEC;
	localparam rcsr_op_type    OP_RST    = OP_NONE;

	// classify one instruction word
	function automatic rcsr_op_type op_of(input logic [15:0] word);
		rcsr_op_type r;
		r = OP_NONE;
		if (word[PREFIX_MSB:PREFIX_LSB] == CALL_PREFIX) begin
			r = OP_CALL;
		end else if (word == RESET_OPCODE) begin
			r = OP_RESET;
		end
		return r;
	endfunction : op_of

endpackage : rcsr_pkg

// >>> logic/rcsr_q_if.sv
`timescale 1ns/1ps
interface rcsr_q_if;
	logic                     q_tick;
	rcsr_pkg::rcsr_phase_type phase;

	modport src (output q_tick, output phase);
	modport snk (input q_tick, input phase);
endinterface : rcsr_q_if

// >>> logic/rcsr_qphase.sv
`timescale 1ns/1ps
module rcsr_qphase #(
	parameter int CLKS_PER_Q = rcsr_pkg::Q_CLKS_DEF
) (
	input wire logic clk,
	input wire logic rst,
	rcsr_q_if.src    q
);
	localparam int CW = (CLKS_PER_Q > 1) ? $clog2(CLKS_PER_Q) : 1;

	if (CLKS_PER_Q < 1) begin : g_bad_clks
		$error("rcsr_qphase: CLKS_PER_Q must be at least 1");
	end

	logic [CW-1:0]            cnt;
	logic [CW-1:0]            next_cnt;
	rcsr_pkg::rcsr_phase_type ph;
	rcsr_pkg::rcsr_phase_type next_ph;
	logic                     tick;

	// tick marks the last clock of each phase
	assign tick     = (cnt == CW'(CLKS_PER_Q - 1));
	assign q.q_tick = tick;
	assign q.phase  = ph;

	always_comb begin
		next_cnt = cnt + CW'(1);
		next_ph  = ph;
		if (tick) begin
			next_cnt = '0;
			next_ph  = rcsr_pkg::rcsr_phase_type'(ph + 2'h1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= '0;
			ph  <= rcsr_pkg::PHASE_RST;
		end else begin
			cnt <= next_cnt;
			ph  <= next_ph;
		end
	end
endmodule : rcsr_qphase

// >>> logic/rcsr_decode.sv
`timescale 1ns/1ps
module rcsr_decode (
	input  wire logic [15:0]                    opcode,
	output rcsr_pkg::rcsr_op_type               op,
	output logic [rcsr_pkg::OFF_WIDTH-1:0]      offset
);
	// low eleven bits carry the signed call offset
	assign op     = rcsr_pkg::op_of(opcode);
	assign offset = opcode[rcsr_pkg::OFF_WIDTH-1:0];
endmodule : rcsr_decode

// >>> dv/rcsr_core_test.sv
`timescale 1ns/1ps
module rcsr_core_test;
	localparam int PCW = 21;

	logic            clk;
	logic            rst;
	logic [15:0]     opcode;
	logic            opcode_valid;
	logic [PCW-1:0]  pc_now;
	logic            push_strobe;
	logic [PCW-1:0]  push_addr;
	logic            pc_load;
	logic [PCW-1:0]  pc_target;
	logic            master_clear_pin_reset_req;
	logic            refill_busy;
	logic            flags_freeze;
	int              error_cnt;
	int              total_checks;

	rcsr_core #(
		.PC_WIDTH   (PCW),
		.CLKS_PER_Q (1)
	) dut_u (
		.clk                        (clk),
		.rst                        (rst),
		.opcode                     (opcode),
		.opcode_valid               (opcode_valid),
		.pc_now                     (pc_now),
		.push_strobe                (push_strobe),
		.push_addr                  (push_addr),
		.pc_load                    (pc_load),
		.pc_target                  (pc_target),
		.master_clear_pin_reset_req (master_clear_pin_reset_req),
		.refill_busy                (refill_busy),
		.flags_freeze               (flags_freeze)
	);

	always #2.5 clk = ~clk;

	// one clock, then settle past the edge
	task automatic step();
		@(posedge clk);
		#1;
	endtask : step

	// outputs packed as push, load, reset request, refill, freeze
	task automatic chk_outs(input logic [4:0] exp, input string what);
		logic [4:0] got;
		got = {push_strobe, pc_load, master_clear_pin_reset_req, refill_busy, flags_freeze};
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t %s: outputs %b expected %b", $time, what, got, exp);
		end
	endtask : chk_outs

	task automatic chk_addr(input logic [PCW-1:0] got, input logic [PCW-1:0] exp,
			input string what);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_addr

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	// call issued at a q1 slot; ends just before the next q1 take edge
	task automatic call_case(input logic [PCW-1:0] pc, input logic [10:0] n);
		logic [PCW-1:0] target;
		target       = pc + 21'h2 + {{9{n[10]}}, n, 1'b0};
		opcode       = {5'h1b, n};
		opcode_valid = 1'b1;
		pc_now       = pc;
		step();
		chk_outs(5'b10001, "call push");
		chk_addr(push_addr, pc + 21'h2, "return address");
		opcode_valid = 1'b0;
		opcode       = 16'h00ff;
		step();
		chk_outs(5'b00001, "call q3");
		chk_addr(pc_target, target, "call target");
		step();
		chk_outs(5'b01001, "call pc write");
		opcode_valid = 1'b1;
		step();
		chk_outs(5'b00011, "refill start");
		step();
		chk_outs(5'b00011, "refill word discarded");
		opcode_valid = 1'b0;
		step();
		step();
		step();
		chk_outs(5'b00000, "refill end");
		$display("test call pc %h offset %h done", pc, n);
	endtask : call_case

	// a word that must produce nothing over a whole cycle
	task automatic idle_case(input logic [15:0] op, input logic v);
		opcode       = op;
		opcode_valid = v;
		for (int i = 0; i < 4; i++) begin
			step();
			chk_outs(5'b00000, "ignored word");
			opcode_valid = 1'b0;
		end
		$display("test ignored word %h valid %b done", op, v);
	endtask : idle_case

	// software reset request, then the bench drives rst and checks the clear
	task automatic reset_case();
		call_case(21'h124, 11'h3ff);
		opcode       = 16'h00ff;
		opcode_valid = 1'b1;
		pc_now       = 21'h124;
		step();
		chk_outs(5'b00100, "soft reset request");
		opcode_valid = 1'b0;
		step();
		chk_outs(5'b00000, "soft reset one clock");
		step();
		step();
		rst = 1'b1;
		step();
		chk_outs(5'b00000, "outputs cleared");
		chk_addr(push_addr, 21'h0, "return address cleared");
		chk_addr(pc_target, 21'h0, "target cleared");
		rst = 1'b0;
		$display("test soft reset done");
	endtask : reset_case

	initial begin
		clk          = 1'b0;
		rst          = 1'b1;
		opcode       = 16'h0000;
		opcode_valid = 1'b0;
		pc_now       = 21'h0;
		error_cnt    = 0;
		total_checks = 0;
		step();
		step();
		step();
		rst = 1'b0;
		call_case(21'h124, 11'h000);
		call_case(21'h124, 11'h3ff);
		call_case(21'h1000, 11'h400);
		call_case(21'h1ffffe, 11'h7ff);
		idle_case(16'hd7ff, 1'b1);
		idle_case(16'h00fe, 1'b1);
		idle_case(16'h01ff, 1'b1);
		idle_case(16'hd800, 1'b0);
		reset_case();
		call_case(21'h200, 11'h010);
		finish_test();
	end

	initial begin
		#10000;
		error_cnt++;
		$display("FAIL %0t watchdog expired", $time);
		finish_test();
	end
endmodule : rcsr_core_test
